// File: logic/sdrc_ctrl.sv
// reset, force-off and slew control of a two-channel solenoid driver
// assumes decoded serial commands, a supply monitor and fault events as synchronous inputs
//
// Overview of operation
// RL1 - reset zeroes currents, restores register defaults
// RL2 - reset clears every latched fault bit
// RL3 - outputs stay off until a command
// RL4 - logic supply undervoltage acts as reset
// RL5 - force-off holds zero current and defaults
// RL6 - commands during force-off are discarded
// RL7 - serial output undriven during force-off
// RL8 - force-off keeps latched fault bits
// RL9 - after force-off, stay off until commanded
// RL10 - host drives force-off while supply low
// RL11 - diagnostics invalid while supply below minimum
// RL12 - open force-off pin reads as asserted
// RL13 - factory test pin tied to ground
// RL14 - two-bit slew code selects edge time
// RL15 - force-off synchronised before gating anything
`timescale 1ns/1ps

module sdrc_ctrl
	import sdrc_pkg::*;
(
	// clock and power-on reset
	input wire logic clk,
	input wire logic rst,
	// supply monitor
	input wire logic vdd_undervoltage,
	input wire logic vdd_below_min,
	// force-off pin
	input wire logic force_off_level,
	input wire logic force_off_connected,
	// decoded serial commands
	input wire logic cmd_valid,
	input wire sdrc_cmd_type cmd,
	output logic cmd_taken,
	output logic cmd_dropped,
	// serial data output pin
	input wire logic so_frame,
	input wire logic so_bit,
	output logic so_out,
	output logic so_oe_n,
	// fault register
	input wire logic [FAULT_W-1:0] fault_event,
	input wire logic fault_read_clear,
	output logic [FAULT_W-1:0] fault_bits,
	output logic fault_valid,
	// channel a
	output logic [CUR_W-1:0] current_a,
	output logic [SLEW_W-1:0] slew_a,
	output logic [EDGE_W-1:0] edge_cycles_a,
	output logic low_side_output_a,
	// channel b
	output logic [CUR_W-1:0] current_b,
	output logic [SLEW_W-1:0] slew_b,
	output logic [EDGE_W-1:0] edge_cycles_b,
	output logic low_side_output_b
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [EDGE_W-1:0] slew_cycles(input logic [SLEW_W-1:0] code);
		logic [EDGE_W-1:0] res;
		res = EDGE_CYC_0;
		case (code)
			SLEW_1: res = EDGE_CYC_1;
			SLEW_2: res = EDGE_CYC_2;
			SLEW_3: res = EDGE_CYC_3;
			default: res = EDGE_CYC_0;
		endcase
		return res;
	endfunction

	sdrc_state_type st;
	sdrc_state_type next_st;
	logic force_off_eff;
	logic so_enable;

	// an unconnected pin floats high through the internal pull-up
	assign force_off_eff = force_off_level | ~force_off_connected; // RL12
	assign so_enable = so_frame & ~st.fo_sync;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.fo_meta = force_off_eff;
		next_st.fo_sync = st.fo_meta; // RL15
		next_st.cmd_taken = 1'b0;
		next_st.cmd_dropped = 1'b0;
		// set wins over read-clear; events ignored while diagnostics are invalid
		next_st.faults = (st.faults & ~(fault_read_clear ? FAULT_ALL : FAULT_NONE))
			| (vdd_below_min ? FAULT_NONE : fault_event); // RL8 RL11
		next_st.fault_valid = ~vdd_below_min; // RL11
		next_st.so_oe_n = ~so_enable; // RL7
		next_st.so_out = so_enable & so_bit;
		if (st.fo_sync) begin
			// forced defaults; faults are left alone
			next_st.mode = SDRC_FORCED;
			next_st.chan = {CHAN_DEFAULT, CHAN_DEFAULT}; // RL5
			next_st.cmd_dropped = cmd_valid; // RL6
		end else begin
			case (st.mode)
				SDRC_RESET: begin
					next_st.mode = SDRC_IDLE_OFF;
				end
				SDRC_FORCED: begin
					// leave force-off with everything still at defaults
					next_st.mode = SDRC_IDLE_OFF; // RL9
				end
				SDRC_IDLE_OFF, SDRC_ACTIVE: begin
					if (cmd_valid) begin
						next_st.cmd_taken = 1'b1;
						case (cmd.kind)
							SDRC_CMD_CURRENT: begin
								next_st.chan[cmd.channel].current = cmd.data;
								next_st.chan[cmd.channel].enable = 1'b1; // RL3
								next_st.mode = SDRC_ACTIVE;
							end
							SDRC_CMD_SLEW: begin
								next_st.chan[cmd.channel].slew = cmd.data[SLEW_W-1:0]; // RL14
							end
							default: begin
							end
						endcase
					end
				end
				default: begin
					next_st.mode = SDRC_RESET;
				end
			endcase
		end
		for (int i = 0; i < NCH; i++) begin
			next_st.edge_cyc[i] = slew_cycles(next_st.chan[i].slew); // RL14
		end
		if (vdd_undervoltage) begin
			// same as power-on, but keep the synchroniser running
			next_st = STATE_RESET; // RL4
			next_st.fo_meta = force_off_eff;
			next_st.fo_sync = st.fo_meta;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= STATE_RESET; // RL1 RL2
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign cmd_taken = st.cmd_taken;
	assign cmd_dropped = st.cmd_dropped;
	assign so_out = st.so_out;
	assign so_oe_n = st.so_oe_n;
	assign fault_bits = st.faults;
	assign fault_valid = st.fault_valid;
	assign current_a = st.chan[0].current;
	assign slew_a = st.chan[0].slew;
	assign edge_cycles_a = st.edge_cyc[0];
	assign low_side_output_a = st.chan[0].enable;
	assign current_b = st.chan[1].current;
	assign slew_b = st.chan[1].slew;
	assign edge_cycles_b = st.edge_cyc[1];
	assign low_side_output_b = st.chan[1].enable;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	por_defaults_a: assert property ($fell(rst) |-> current_a == CUR_DEFAULT // RL1
		&& current_b == CUR_DEFAULT && slew_a == SLEW_DEFAULT && slew_b == SLEW_DEFAULT)
		else $error("registers not at defaults after reset");

	por_faults_a: assert property ($fell(rst) |-> fault_bits == FAULT_NONE) // RL2
		else $error("faults not cleared by reset");

	enable_cause_a: assert property ($rose(low_side_output_a) |-> // RL3
		$past(cmd_valid && cmd.kind == SDRC_CMD_CURRENT && cmd.channel == 1'b0 && !st.fo_sync))
		else $error("output enabled without a current command");

	uv_reset_a: assert property (vdd_undervoltage |=> fault_bits == FAULT_NONE // RL4
		&& !low_side_output_a && !low_side_output_b && st.mode == SDRC_RESET)
		else $error("undervoltage did not reset");

	forced_zero_a: assert property (st.fo_sync |=> current_a == CUR_DEFAULT // RL5
		&& current_b == CUR_DEFAULT && !low_side_output_a && !low_side_output_b)
		else $error("force-off did not zero the channels");

	forced_drop_a: assert property (st.fo_sync && cmd_valid && !vdd_undervoltage // RL6
		|=> cmd_dropped && !cmd_taken)
		else $error("command not discarded in force-off");

	so_hiz_a: assert property (st.fo_sync |=> so_oe_n && !so_out) // RL7
		else $error("serial output driven in force-off");

	fault_keep_a: assert property (st.fo_sync && !vdd_undervoltage && !fault_read_clear // RL8
		|=> (fault_bits & $past(fault_bits)) == $past(fault_bits))
		else $error("force-off cleared a fault");

	exit_off_a: assert property ($fell(st.fo_sync) && !vdd_undervoltage // RL9
		|=> !low_side_output_a && !low_side_output_b && current_a == CUR_DEFAULT)
		else $error("channel on right after force-off");

	diag_invalid_a: assert property (vdd_below_min |=> !fault_valid) // RL11
		else $error("faults valid with supply low");

	pin_open_a: assert property (!force_off_connected [*2] |=> st.fo_sync) // RL12
		else $error("open force-off pin not seen as asserted");

	slew_map_a: assert property (slew_a == SLEW_3 |-> edge_cycles_a == EDGE_CYC_3) // RL14
		else $error("slew code 3 gives wrong edge time");

	sync_lag_a: assert property ($rose(force_off_eff) && !$past(rst) |=> !st.fo_sync) // RL15
		else $error("force-off gated without synchronisation");

	uv_quiet_a: assert property (vdd_undervoltage |=> !cmd_taken && !cmd_dropped) // RL4
		else $error("command answered during undervoltage");

	uv_sync_a: assert property (vdd_undervoltage |=> // RL15
		st.fo_meta == $past(force_off_eff) && st.fo_sync == $past(st.fo_meta))
		else $error("synchroniser stopped by undervoltage");

	forced_mode_a: assert property (st.fo_sync && !vdd_undervoltage // RL5
		|=> st.mode == SDRC_FORCED)
		else $error("force-off did not enter forced mode");

	exit_quiet_a: assert property (st.mode == SDRC_FORCED && !st.fo_sync // RL9
		&& !vdd_undervoltage |=> !cmd_taken && !cmd_dropped)
		else $error("command answered while leaving force-off");

	so_follow_a: assert property (so_frame && !st.fo_sync && !vdd_undervoltage // RL7
		|=> !so_oe_n && so_out == $past(so_bit))
		else $error("serial output not driven in a frame");

	taken_cause_a: assert property (cmd_taken |-> $past(cmd_valid && !st.fo_sync)) // RL6
		else $error("command taken without a request");

	drop_cause_a: assert property (cmd_dropped |-> $past(cmd_valid && st.fo_sync)) // RL6
		else $error("command dropped outside force-off");

	pulse_excl_a: assert property (!(cmd_taken && cmd_dropped)) // RL6
		else $error("command both taken and dropped");

	load_a_a: assert property (cmd_valid && cmd.kind == SDRC_CMD_CURRENT && !cmd.channel // RL3
		&& !st.fo_sync && !vdd_undervoltage && st.mode inside {SDRC_IDLE_OFF, SDRC_ACTIVE}
		|=> low_side_output_a && current_a == $past(cmd.data) && st.mode == SDRC_ACTIVE)
		else $error("current command for channel a not applied");

	load_b_a: assert property (cmd_valid && cmd.kind == SDRC_CMD_CURRENT && cmd.channel // RL3
		&& !st.fo_sync && !vdd_undervoltage && st.mode inside {SDRC_IDLE_OFF, SDRC_ACTIVE}
		|=> low_side_output_b && current_b == $past(cmd.data) && st.mode == SDRC_ACTIVE)
		else $error("current command for channel b not applied");

	set_wins_a: assert property (fault_read_clear && !vdd_below_min // RL8
		&& !vdd_undervoltage |=> (fault_bits & $past(fault_event)) == $past(fault_event))
		else $error("fault event lost to a read clear");

	read_clear_a: assert property (fault_read_clear && !vdd_undervoltage // RL11
		&& (vdd_below_min || fault_event == FAULT_NONE) |=> fault_bits == FAULT_NONE)
		else $error("read clear left a fault set");

	valid_back_a: assert property (!vdd_below_min && !vdd_undervoltage |=> fault_valid) // RL11
		else $error("diagnostics not valid with supply good");

	// ----------------------------------------------------------------
	// edge time per slew code
	// ----------------------------------------------------------------
	edge_a0_a: assert property (slew_a == SLEW_DEFAULT |-> edge_cycles_a == EDGE_CYC_0) // RL14
		else $error("slew code 0 gives wrong edge time on a");

	edge_a1_a: assert property (slew_a == SLEW_1 |-> edge_cycles_a == EDGE_CYC_1) // RL14
		else $error("slew code 1 gives wrong edge time on a");

	edge_a2_a: assert property (slew_a == SLEW_2 |-> edge_cycles_a == EDGE_CYC_2) // RL14
		else $error("slew code 2 gives wrong edge time on a");

	edge_b0_a: assert property (slew_b == SLEW_DEFAULT |-> edge_cycles_b == EDGE_CYC_0) // RL14
		else $error("slew code 0 gives wrong edge time on b");

	edge_b1_a: assert property (slew_b == SLEW_1 |-> edge_cycles_b == EDGE_CYC_1) // RL14
		else $error("slew code 1 gives wrong edge time on b");

	edge_b2_a: assert property (slew_b == SLEW_2 |-> edge_cycles_b == EDGE_CYC_2) // RL14
		else $error("slew code 2 gives wrong edge time on b");

	edge_b3_a: assert property (slew_b == SLEW_3 |-> edge_cycles_b == EDGE_CYC_3) // RL14
		else $error("slew code 3 gives wrong edge time on b");

	cover_take_c: cover property (cmd_valid && cmd.kind == SDRC_CMD_CURRENT ##1 cmd_taken);
	cover_drop_c: cover property (cmd_dropped);
	cover_resume_c: cover property (st.fo_sync ##1 !st.fo_sync [*3] ##1 low_side_output_b);
	cover_fault_forced_c: cover property (st.fo_sync && fault_bits != FAULT_NONE);
	cover_uv_c: cover property (vdd_undervoltage ##1 !vdd_undervoltage ##[1:8] cmd_taken);

endmodule

// File: logic/sdrc_pkg.sv
// constants, enumerations and carrier structs for the reset and force-off control
// assumes one 250 MHz clock and already-decoded serial commands
package sdrc_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int NCH = 2;
	localparam int CUR_W = 10;
	localparam int SLEW_W = 2;
	localparam int FAULT_W = 4;
	localparam int EDGE_W = 11;

	// ----------------------------------------------------------------
	// defaults
	// ----------------------------------------------------------------
	localparam logic [CUR_W-1:0] CUR_DEFAULT = 10'h000;
	localparam logic [SLEW_W-1:0] SLEW_DEFAULT = 2'h0;
	localparam logic [FAULT_W-1:0] FAULT_NONE = 4'h0;
	localparam logic [FAULT_W-1:0] FAULT_ALL = 4'hF;

	// ----------------------------------------------------------------
	// edge times per slew code, typical, and their cycle counts
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int EDGE_NS_0 = 500;
	localparam int EDGE_NS_1 = 1000;
	localparam int EDGE_NS_2 = 2000;
	localparam int EDGE_NS_3 = 5000;
	localparam logic [EDGE_W-1:0] EDGE_CYC_0 = EDGE_W'(EDGE_NS_0 * CLK_MHZ / 1000);
	localparam logic [EDGE_W-1:0] EDGE_CYC_1 = EDGE_W'(EDGE_NS_1 * CLK_MHZ / 1000);
	localparam logic [EDGE_W-1:0] EDGE_CYC_2 = EDGE_W'(EDGE_NS_2 * CLK_MHZ / 1000);
	localparam logic [EDGE_W-1:0] EDGE_CYC_3 = EDGE_W'(EDGE_NS_3 * CLK_MHZ / 1000);
	localparam logic [SLEW_W-1:0] SLEW_1 = 2'h1;
	localparam logic [SLEW_W-1:0] SLEW_2 = 2'h2;
	localparam logic [SLEW_W-1:0] SLEW_3 = 2'h3;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SDRC_CMD_CURRENT = 2'b00,
		SDRC_CMD_SLEW = 2'b01,
		SDRC_CMD_READ = 2'b10,
		SDRC_CMD_NOP = 2'b11
	} sdrc_cmd_kind_type;

	typedef enum logic [1:0] {
		SDRC_RESET = 2'b00,
		SDRC_IDLE_OFF = 2'b01,
		SDRC_ACTIVE = 2'b10,
		SDRC_FORCED = 2'b11
	} sdrc_mode_type;

	typedef struct packed {
		sdrc_cmd_kind_type kind;
		logic channel;
		logic [CUR_W-1:0] data;
	} sdrc_cmd_type;

	typedef struct packed {
		logic [CUR_W-1:0] current;
		logic [SLEW_W-1:0] slew;
		logic enable;
	} sdrc_chan_type;

	localparam sdrc_chan_type CHAN_DEFAULT = '{CUR_DEFAULT, SLEW_DEFAULT, 1'b0};

	typedef struct packed {
		logic fo_meta;
		logic fo_sync;
		sdrc_mode_type mode;
		sdrc_chan_type [NCH-1:0] chan;
		logic [NCH-1:0][EDGE_W-1:0] edge_cyc;
		logic [FAULT_W-1:0] faults;
		logic fault_valid;
		logic so_out;
		logic so_oe_n;
		logic cmd_taken;
		logic cmd_dropped;
	} sdrc_state_type;

	localparam sdrc_state_type STATE_RESET = '{
		fo_meta: 1'b1,
		fo_sync: 1'b1,
		mode: SDRC_RESET,
		chan: {CHAN_DEFAULT, CHAN_DEFAULT},
		edge_cyc: {EDGE_CYC_0, EDGE_CYC_0},
		faults: FAULT_NONE,
		fault_valid: 1'b0,
		so_out: 1'b0,
		so_oe_n: 1'b1,
		cmd_taken: 1'b0,
		cmd_dropped: 1'b0
	};

endpackage

// File: bench/sdrc_host.sv
// host side model: decoded commands and the force-off pin
// assumes bench requests launched just after a rising edge
`timescale 1ns/1ps

module sdrc_host
	import sdrc_pkg::*;
(
	// clock
	input wire logic clk,
	// requests from the bench
	input wire logic req,
	input wire sdrc_cmd_type req_cmd,
	input wire logic fo_req,
	input wire logic supply_low,
	// toward the device
	output logic cmd_valid,
	output sdrc_cmd_type cmd,
	output logic force_off_level,
	// factory test pin, tied low on the board
	output logic factory_test
);
	sdrc_cmd_type last = '0;

	always_ff @(posedge clk) begin
		if (req) begin
			last <= req_cmd;
		end
	end

	// idle command lines show the inverse of the last word
	assign cmd_valid = req;
	assign cmd = req ? req_cmd : ~last;
	assign force_off_level = fo_req | supply_low;
	assign factory_test = 1'b0;
endmodule

// File: bench/sdrc_ctrl_bench.sv
// self-checking bench of the reset and force-off control
// assumes the host model and a 250 MHz clock
`timescale 1ns/1ps

module sdrc_ctrl_bench
	import sdrc_pkg::*;
;
	typedef struct packed {
		logic [1:0] k;
		logic c;
		logic [9:0] d, ac;
		logic [1:0] sa;
		logic ea;
		logic [9:0] bc;
		logic [1:0] sb;
		logic eb;
	} sdrc_row_type;

	localparam sdrc_row_type ROWS [8] = '{
		'{2'h0, 1'h0, 10'h3FF, 10'h3FF, 2'h0, 1'h1, 10'h000, 2'h0, 1'h0},
		'{2'h1, 1'h0, 10'h003, 10'h3FF, 2'h3, 1'h1, 10'h000, 2'h0, 1'h0},
		'{2'h1, 1'h1, 10'h001, 10'h3FF, 2'h3, 1'h1, 10'h000, 2'h1, 1'h0},
		'{2'h0, 1'h1, 10'h000, 10'h3FF, 2'h3, 1'h1, 10'h000, 2'h1, 1'h1},
		'{2'h1, 1'h1, 10'h3FE, 10'h3FF, 2'h3, 1'h1, 10'h000, 2'h2, 1'h1},
		'{2'h2, 1'h0, 10'h2AA, 10'h3FF, 2'h3, 1'h1, 10'h000, 2'h2, 1'h1},
		'{2'h3, 1'h1, 10'h155, 10'h3FF, 2'h3, 1'h1, 10'h000, 2'h2, 1'h1},
		'{2'h0, 1'h1, 10'h155, 10'h3FF, 2'h3, 1'h1, 10'h155, 2'h2, 1'h1}
	};
	localparam logic [47:0] DEF = {2{24'h0000FA}};

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic vdd_undervoltage = 1'b0;
	logic vdd_below_min = 1'b0;
	logic fo_req = 1'b0;
	logic force_off_connected = 1'b1;
	logic req = 1'b0;
	sdrc_cmd_type req_cmd = '0;
	logic so_frame = 1'b0;
	logic so_bit = 1'b0;
	logic [FAULT_W-1:0] fault_event = '0;
	logic fault_read_clear = 1'b0;
	logic cmd_valid, force_off_level, cmd_taken, cmd_dropped, so_out, so_oe_n, fault_valid;
	sdrc_cmd_type cmd;
	logic [FAULT_W-1:0] fault_bits;
	logic [CUR_W-1:0] current_a, current_b;
	logic [SLEW_W-1:0] slew_a, slew_b;
	logic [EDGE_W-1:0] edge_cycles_a, edge_cycles_b;
	logic low_side_output_a, low_side_output_b;
	wire [47:0] chans = {current_a, slew_a, edge_cycles_a, low_side_output_a,
		current_b, slew_b, edge_cycles_b, low_side_output_b};
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;

	sdrc_host u_sdrc_host (.clk, .req, .req_cmd, .fo_req, .supply_low(vdd_below_min),
		.cmd_valid, .cmd, .force_off_level, .factory_test());
	sdrc_ctrl u_sdrc_ctrl (.clk, .rst, .vdd_undervoltage, .vdd_below_min, .force_off_level,
		.force_off_connected, .cmd_valid, .cmd, .cmd_taken, .cmd_dropped, .so_frame, .so_bit,
		.so_out, .so_oe_n, .fault_event, .fault_read_clear, .fault_bits, .fault_valid,
		.current_a, .slew_a, .edge_cycles_a, .low_side_output_a,
		.current_b, .slew_b, .edge_cycles_b, .low_side_output_b);

	always #2 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			wrap_up();
		end
	end

	function automatic logic [10:0] edge_of(input logic [1:0] s);
		case (s)
			2'h0: return 11'h07D;
			2'h1: return 11'h0FA;
			2'h2: return 11'h1F4;
			default: return 11'h4E2;
		endcase
	endfunction

	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic send(input logic [1:0] k, input logic c, input logic [9:0] d, input logic ok);
		@(posedge clk);
		req <= 1'b1;
		req_cmd <= '{sdrc_cmd_kind_type'(k), c, d};
		@(posedge clk);
		req <= 1'b0;
		#1;
		chk(48'({cmd_taken, cmd_dropped}), 48'({ok, ~ok}));
	endtask

	task automatic wrap_up();
		if (failures == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		tick(2);
		chk(chans, DEF);
		chk(48'({fault_bits, fault_valid, so_oe_n}), 48'h1);
		@(posedge clk);
		rst <= 1'b0;
		tick(4);
		chk(48'(fault_valid), 48'h1);
		foreach (ROWS[i]) begin
			send(ROWS[i].k, ROWS[i].c, ROWS[i].d, 1'b1);
			chk(chans, {ROWS[i].ac, ROWS[i].sa, edge_of(ROWS[i].sa), ROWS[i].ea,
				ROWS[i].bc, ROWS[i].sb, edge_of(ROWS[i].sb), ROWS[i].eb});
		end
		@(posedge clk);
		so_frame <= 1'b1;
		so_bit <= 1'b1;
		fault_event <= 4'h5;
		@(posedge clk);
		fault_event <= 4'h0;
		tick(1);
		chk(48'({so_oe_n, so_out, fault_bits}), 48'h15);
		@(posedge clk);
		fo_req <= 1'b1;
		tick(4);
		chk(chans, DEF);
		chk(48'({so_oe_n, fault_bits}), 48'h15);
		send(2'h0, 1'h0, 10'h3FF, 1'b0);
		chk(chans, DEF);
		@(posedge clk);
		fo_req <= 1'b0;
		tick(6);
		chk(chans, DEF);
		send(2'h0, 1'h0, 10'h200, 1'b1);
		chk(48'(current_a), 48'h200);
		@(posedge clk);
		fault_read_clear <= 1'b1;
		fault_event <= 4'h8;
		force_off_connected <= 1'b0;
		@(posedge clk);
		fault_read_clear <= 1'b0;
		fault_event <= 4'h0;
		tick(4);
		chk(48'({fault_bits, low_side_output_a}), 48'h10);
		send(2'h1, 1'h0, 10'h003, 1'b0);
		@(posedge clk);
		force_off_connected <= 1'b1;
		vdd_below_min <= 1'b1;
		fault_event <= 4'hF;
		fault_read_clear <= 1'b1;
		@(posedge clk);
		fault_read_clear <= 1'b0;
		tick(3);
		chk(48'({fault_bits, fault_valid}), 48'h0);
		send(2'h0, 1'h1, 10'h0AA, 1'b0);
		@(posedge clk);
		vdd_below_min <= 1'b0;
		fault_event <= 4'h2;
		@(posedge clk);
		fault_event <= 4'h0;
		tick(6);
		send(2'h0, 1'h1, 10'h0AA, 1'b1);
		chk(48'({fault_bits, current_b}), 48'h08AA);
		@(posedge clk);
		vdd_undervoltage <= 1'b1;
		tick(2);
		chk(chans, DEF);
		chk(48'(fault_bits), 48'h0);
		@(posedge clk);
		vdd_undervoltage <= 1'b0;
		tick(4);
		send(2'h1, 1'h1, 10'h001, 1'b1);
		wrap_up();
	end
endmodule
